// File: hw/i2csw_params.svh
// constants for the i2c switch host controller: offsets, fields, reset values, timing
`ifndef I2CSW_PARAMS_SVH
`define I2CSW_PARAMS_SVH
`define I2CSW_CTRL_OFF      12'h000
`define I2CSW_ADDR_OFF      12'h004
`define I2CSW_WDATA_OFF     12'h008
`define I2CSW_STAT_OFF      12'h00C
`define I2CSW_CTRL_GO_BIT   0
`define I2CSW_CTRL_READ_BIT 1
`define I2CSW_CTRL_RST_BIT  2
`define I2CSW_STAT_BUSY_BIT 0
`define I2CSW_STAT_DONE_BIT 1
`define I2CSW_STAT_NACK_BIT 2
`define I2CSW_STAT_RD_LSB   8
`define I2CSW_ADDR_RESET    7'h00
`define I2CSW_WDATA_RESET   8'h00
`define I2CSW_BYTE_BITS     4'h8
`define I2CSW_CNT_W         16
`define I2CSW_PCLK_NS       5
`define I2CSW_SCL_QTR_NS    2500
`define I2CSW_RST_LOW_NS    500
`endif

// File: hw/i2csw_pkg.sv
// types of the i2c switch host controller
`include "i2csw_params.svh"
package i2csw_pkg;
  typedef enum logic [2:0] {I2CSW_IDLE, I2CSW_BUSWAIT, I2CSW_START, I2CSW_BIT, I2CSW_STOP,
                            I2CSW_RSTP} i2csw_fsm_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } i2csw_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } i2csw_apb_rsp_type;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
    logic switch_reset_n;
  } i2csw_pin_out_type;

  typedef struct packed {
    i2csw_fsm_type           fsm;
    logic [`I2CSW_CNT_W-1:0] cnt;
    logic [1:0]              phase;
    logic [3:0]              bitn;
    logic                    byten;
    logic [7:0]              shreg;
    logic [7:0]              rdata;
    logic [6:0]              addr;
    logic [7:0]              wdata;
    logic                    dir;
    logic                    done;
    logic                    nack;
    logic                    scl_oe;
    logic                    sda_oe;
    logic                    swrst_n;
    logic                    scl_m;
    logic                    scl_s;
    logic                    sda_m;
    logic                    sda_s;
    logic [31:0]             prdata;
    logic                    pslverr;
  } i2csw_regs_type;
endpackage

// File: hw/i2csw_host.sv
// host controller that drives the eight-channel i2c switch over scl/sda and its reset pin
//
// Notes on behaviour
// - reset pin low clears switch, all channels off
// - start only when scl and sda high
// - sda changes only while scl low
// - eight data bits then one acknowledge bit
// - master gives ninth clock, transmitter releases sda
// - master reader leaves last byte unacknowledged
// - write loads control byte, read returns it
// - address lsb one reads, zero writes
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "i2csw_params.svh"
module i2csw_host #(
  parameter logic [`I2CSW_CNT_W-1:0] QTR_CYC =
    `I2CSW_CNT_W'((`I2CSW_SCL_QTR_NS + `I2CSW_PCLK_NS - 1) / `I2CSW_PCLK_NS),
  parameter logic [`I2CSW_CNT_W-1:0] RST_CYC =
    `I2CSW_CNT_W'((`I2CSW_RST_LOW_NS + `I2CSW_PCLK_NS - 1) / `I2CSW_PCLK_NS)
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire i2csw_pkg::i2csw_apb_req_type apb_req,
  output      i2csw_pkg::i2csw_apb_rsp_type apb_rsp,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output      i2csw_pkg::i2csw_pin_out_type pins
);
  import i2csw_pkg::*;

  // everything after async reset: switch reset pin held low, lines released
  localparam i2csw_regs_type RST_VAL = '{
    fsm:     I2CSW_RSTP,
    cnt:     '0,
    phase:   2'h0,
    bitn:    4'h0,
    byten:   1'b0,
    shreg:   8'h00,
    rdata:   8'h00,
    addr:    `I2CSW_ADDR_RESET,
    wdata:   `I2CSW_WDATA_RESET,
    dir:     1'b0,
    done:    1'b0,
    nack:    1'b0,
    scl_oe:  1'b0,
    sda_oe:  1'b0,
    swrst_n: 1'b0,
    scl_m:   1'b1,
    scl_s:   1'b1,
    sda_m:   1'b1,
    sda_s:   1'b1,
    prdata:  32'h0000_0000,
    pslverr: 1'b0
  };

  i2csw_regs_type s;
  i2csw_regs_type next_s;

  logic setup_rd;
  logic access;
  logic mapped;
  logic busy;
  logic rx_byte;
  logic phase_end;
  logic [31:0] rd_word;
  logic [`I2CSW_CNT_W-1:0] cnt_step;

  // apb handshake: zero wait states, every access answered in its first access cycle
  assign apb_rsp.pready  = apb_req.psel & apb_req.penable;
  assign apb_rsp.prdata  = s.prdata;
  assign apb_rsp.pslverr = s.pslverr & apb_req.psel & apb_req.penable;

  // open-drain pins: output level is always low, only the enables move
  assign pins.scl_o          = 1'b0;
  assign pins.sda_o          = 1'b0;
  assign pins.scl_oe         = s.scl_oe;
  assign pins.sda_oe         = s.sda_oe;
  assign pins.switch_reset_n = s.swrst_n;

  // decode of the register bus and of the transfer in progress
  always_comb
  begin
    setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    access   = apb_req.psel & apb_req.penable;
    mapped   = (apb_req.paddr == `I2CSW_CTRL_OFF) || (apb_req.paddr == `I2CSW_ADDR_OFF) ||
               (apb_req.paddr == `I2CSW_WDATA_OFF) || (apb_req.paddr == `I2CSW_STAT_OFF);
    busy     = (s.fsm != I2CSW_IDLE);
    rx_byte  = s.byten & s.dir;  // second byte of a read comes from the switch
    rd_word  = 32'h0000_0000;
    case (apb_req.paddr)
      `I2CSW_CTRL_OFF:
      begin
        rd_word[`I2CSW_CTRL_READ_BIT] = s.dir;
        rd_word[`I2CSW_CTRL_RST_BIT]  = (s.fsm == I2CSW_RSTP);
      end
      `I2CSW_ADDR_OFF:  rd_word[6:0] = s.addr;
      `I2CSW_WDATA_OFF: rd_word[7:0] = s.wdata;
      `I2CSW_STAT_OFF:
      begin
        rd_word[`I2CSW_STAT_BUSY_BIT] = busy;
        rd_word[`I2CSW_STAT_DONE_BIT] = s.done;
        rd_word[`I2CSW_STAT_NACK_BIT] = s.nack;
        rd_word[`I2CSW_STAT_RD_LSB +: 8] = s.rdata;
      end
      default:          rd_word = 32'h0000_0000;
    endcase
    // stretching: the first high quarter of a bit or stop only ends once scl really reads high
    phase_end = (s.cnt == QTR_CYC - `I2CSW_CNT_W'(1)) && !((s.phase == 2'h2) && !s.scl_s);
    // a stretched high quarter parks the count on its last value; counting on would miss the end for 2^16 cycles
    if (phase_end)
    begin
      cnt_step = '0;
    end
    else if (s.cnt == QTR_CYC - `I2CSW_CNT_W'(1))
    begin
      cnt_step = s.cnt;
    end
    else
    begin
      cnt_step = s.cnt + `I2CSW_CNT_W'(1);
    end
  end

  // next state of the whole controller
  always_comb
  begin
    next_s = s;
    // two-flop synchronisers on the bus lines
    next_s.scl_m = scl_i;
    next_s.scl_s = s.scl_m;
    next_s.sda_m = sda_i;
    next_s.sda_s = s.sda_m;

    // read data and error are captured in the setup cycle and shown in the access cycle
    if (apb_req.psel && !apb_req.penable)
    begin
      next_s.pslverr = ~mapped;
      if (setup_rd)
      begin
        next_s.prdata = rd_word;
      end
    end

    // register writes; address and data are locked while a transfer runs
    if (access && apb_req.pwrite && !busy)
    begin
      case (apb_req.paddr)
        `I2CSW_ADDR_OFF:  next_s.addr  = apb_req.pwdata[6:0];
        `I2CSW_WDATA_OFF: next_s.wdata = apb_req.pwdata[7:0];
        `I2CSW_CTRL_OFF:
        begin
          if (apb_req.pwdata[`I2CSW_CTRL_RST_BIT])
          begin
            next_s.fsm     = I2CSW_RSTP;
            next_s.cnt     = '0;
            next_s.swrst_n = 1'b0;
          end
          else if (apb_req.pwdata[`I2CSW_CTRL_GO_BIT])
          begin
            next_s.dir  = apb_req.pwdata[`I2CSW_CTRL_READ_BIT];
            next_s.done = 1'b0;
            next_s.nack = 1'b0;
            next_s.fsm  = I2CSW_BUSWAIT;
            next_s.cnt  = '0;
          end
        end
        default: next_s.fsm = s.fsm;
      endcase
    end

    // serial engine; each phase lasts one quarter of an scl period
    case (s.fsm)
      I2CSW_IDLE:
      begin
        next_s.sda_oe = 1'b0;
      end
      I2CSW_RSTP:
      begin
        // switch reset pin held low for its least width; lines left released
        next_s.sda_oe = 1'b0;
        if (s.cnt >= RST_CYC - `I2CSW_CNT_W'(1))
        begin
          next_s.fsm     = I2CSW_IDLE;
          next_s.swrst_n = 1'b1;
          next_s.cnt     = '0;
        end
        else
        begin
          next_s.cnt     = s.cnt + `I2CSW_CNT_W'(1);
          next_s.swrst_n = 1'b0;
        end
      end
      I2CSW_BUSWAIT:
      begin
        // bus counts as free after both lines read high for a whole quarter
        if (!(s.scl_s && s.sda_s))
        begin
          next_s.cnt = '0;
        end
        else if (s.cnt == QTR_CYC - `I2CSW_CNT_W'(1))
        begin
          next_s.fsm    = I2CSW_START;
          next_s.cnt    = '0;
          next_s.phase  = 2'h0;
          next_s.sda_oe = 1'b1;
        end
        else
        begin
          next_s.cnt = s.cnt + `I2CSW_CNT_W'(1);
        end
      end
      I2CSW_START:
      begin
        next_s.cnt = cnt_step;
        if (phase_end)
        begin
          if (s.phase == 2'h0)
          begin
            next_s.phase = 2'h1;  // scl falls after sda has been low a quarter
          end
          else
          begin
            next_s.fsm   = I2CSW_BIT;
            next_s.phase = 2'h0;
            next_s.bitn  = 4'h0;
            next_s.byten = 1'b0;
            next_s.shreg = {s.addr, s.dir};
          end
        end
      end
      I2CSW_BIT:
      begin
        next_s.cnt = cnt_step;
        if (phase_end)
        begin
          next_s.phase = s.phase + 2'h1;
          case (s.phase)
            2'h0:
            begin
              // data moves a quarter after scl fell, far from either edge
              if (s.bitn < `I2CSW_BYTE_BITS && !rx_byte)
              begin
                next_s.sda_oe = ~s.shreg[7];
              end
              else
              begin
                next_s.sda_oe = 1'b0;
              end
            end
            2'h2:
            begin
              // sample in the middle of the high phase
              if (s.bitn < `I2CSW_BYTE_BITS)
              begin
                next_s.shreg = {s.shreg[6:0], s.sda_s};
              end
              else if (!rx_byte)
              begin
                next_s.nack = s.sda_s;
              end
              else
              begin
                next_s.rdata = s.shreg;
              end
            end
            2'h3:
            begin
              if (s.bitn < `I2CSW_BYTE_BITS)
              begin
                next_s.bitn = s.bitn + 4'h1;
              end
              else if (s.nack || s.byten)
              begin
                // one data byte per transfer, or the switch refused
                next_s.fsm   = I2CSW_STOP;
                next_s.phase = 2'h0;
              end
              else
              begin
                next_s.byten = 1'b1;
                next_s.bitn  = 4'h0;
                next_s.shreg = s.wdata;
              end
            end
            default: next_s.phase = s.phase + 2'h1;
          endcase
        end
      end
      I2CSW_STOP:
      begin
        next_s.cnt = cnt_step;
        if (phase_end)
        begin
          next_s.phase = s.phase + 2'h1;
          case (s.phase)
            2'h0:    next_s.sda_oe = 1'b1;  // pull sda low while scl is low
            2'h2:    next_s.sda_oe = 1'b0;
            2'h3:
            begin
              // last quarter gives bus free time before the next start
              next_s.fsm   = I2CSW_IDLE;
              next_s.phase = 2'h0;
              next_s.done  = 1'b1;
            end
            default: next_s.sda_oe = s.sda_oe;
          endcase
        end
      end
      default:
      begin
        next_s.fsm = I2CSW_IDLE;
      end
    endcase

    // scl is driven low in the first half of every bit and stop, and late in start
    next_s.scl_oe = ((next_s.fsm == I2CSW_START) && (next_s.phase == 2'h1)) ||
                    (((next_s.fsm == I2CSW_BIT) || (next_s.fsm == I2CSW_STOP)) && (next_s.phase < 2'h2));
  end

  // single state register; async reset puts the switch in reset at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= RST_VAL;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule

// File: bench/i2csw_switch_model.sv
// behavioural eight-channel switch on the far side of scl/sda
`timescale 1ns/10ps
module i2csw_switch_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       reset_n,
  output logic            sda_oe,
  output logic [7:0]      chan
);
  logic [7:0] ctrl;
  logic [7:0] sh;
  logic       act;
  logic       adr;
  logic       rd;
  int         n;

  // power-up: control, channels, active flag and sda drive zero, nothing selected
  initial
  begin
    ctrl = 8'h00;
    chan = 8'h00;
    act = 1'b0;
    sda_oe = 1'b0;
  end

  // reset pin acts at once, no bus edge needed
  always @(negedge reset_n)
  begin
    ctrl = 8'h00;
    chan = 8'h00;
    act = 1'b0;
    sda_oe = 1'b0;
  end

  // start: sda falls while scl high
  always @(negedge sda)
    if (scl && reset_n)
    begin
      act = 1'b1;
      adr = 1'b1;
      n = 0;
    end

  // stop: new selection only now, lines are high
  always @(posedge sda)
    if (scl)
    begin
      act = 1'b0;
      if (reset_n) chan = ctrl;
    end

  // one bit per pulse, msb first; master nack ends a read
  always @(posedge scl)
    if (act)
    begin
      if (n < 8) sh = {sh[6:0], sda};
      else if (rd && !adr && sda) act = 1'b0;
      n = n + 1;
    end

  // data and ack change only while scl low
  always @(negedge scl)
    if (act)
    begin
      if (n == 9)
      begin
        n = 0;
        adr = 1'b0;
      end
      if (n == 8 && adr && sh[7:1] != DEV_ADDR) act = 1'b0;
      else if (n == 8 && adr) rd = sh[0];
      else if (n == 8 && !rd) ctrl = sh;
      sda_oe = act && (n == 8 ? !(rd && !adr) : (rd && !adr && !ctrl[7-n]));
    end
endmodule

// File: bench/i2csw_host_assertions.sv
// checker on the switch host ports
`timescale 1ns/10ps
module i2csw_host_checker #(
  parameter int QTR_CYC = 8,
  parameter int RST_CYC = 4
) (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire i2csw_pkg::i2csw_apb_req_type apb_req,
  input wire i2csw_pkg::i2csw_apb_rsp_type apb_rsp,
  input wire logic                         scl_i,
  input wire logic                         sda_i,
  input wire i2csw_pkg::i2csw_pin_out_type pins
);
  import i2csw_pkg::*;
  localparam int QLO = QTR_CYC - 1;
  localparam int QHI = QTR_CYC + 2;
  localparam int RHI = RST_CYC + 3;
  logic [4:0] pulses;
  logic [6:0] adr;
  logic [7:0] wdat;
  logic [7:0] eb;
  logic [2:0] bix;
  logic       rd;
  logic       akd;
  logic       wr;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // expected bit on the wire from the last register writes
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign eb = (pulses < 5'h08) ? {adr, rd} : wdat;
  assign bix = 3'(((pulses < 5'h08) ? 5'h07 : 5'h10) - pulses);

  // pulse count since start; ack seen on the address byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulses <= 5'h00;
      adr <= 7'h00;
      wdat <= 8'h00;
      rd <= 1'b0;
      akd <= 1'b0;
    end
    else
    begin
      if ($rose(pins.sda_oe) && !pins.scl_oe)
        pulses <= 5'h00;
      else if ($fell(pins.scl_oe) && pulses != 5'h1f)
        pulses <= pulses + 5'h01;
      if (pulses == 5'h09 && !pins.scl_oe)
        akd <= !sda_i;
      if (wr && apb_req.paddr == 12'h004)
        adr <= apb_req.pwdata[6:0];
      if (wr && apb_req.paddr == 12'h008)
        wdat <= apb_req.pwdata[7:0];
      if (wr && apb_req.paddr == 12'h000 && apb_req.pwdata[0] && !apb_req.pwdata[2])
        rd <= apb_req.pwdata[1];
    end
  end

  a_ready_zero_wait: assert property (apb_rsp.pready == (apb_req.psel && apb_req.penable))
    else $error("pready not zero wait");
  a_unmapped_err: assert property (apb_req.psel && apb_req.penable && apb_req.paddr > 12'h00c |-> apb_rsp.pslverr)
    else $error("no error on unmapped address");
  a_reset_pulse_len: assert property ($rose(presetn) |->
    (!pins.switch_reset_n)[*3] ##[1:RHI] pins.switch_reset_n) else $error("switch reset pulse wrong");
  a_start_bus_idle: assert property ($rose(pins.sda_oe) && !pins.scl_oe |->
    $past(scl_i) && $past(sda_i)) else $error("start on busy bus");
  a_start_then_clock: assert property ($rose(pins.sda_oe) && !pins.scl_oe |->
    pins.sda_oe throughout ##[QLO:QHI] $rose(pins.scl_oe)) else $error("start timing wrong");
  a_sda_hold_high: assert property ($fell(pins.scl_oe) |-> $stable(pins.sda_oe)[*7])
    else $error("sda moved while scl high");
  a_ack_slot_free: assert property ($fell(pins.scl_oe) && (pulses == 5'h08 || pulses == 5'h11) |->
    !pins.sda_oe) else $error("sda held in ack slot");
  a_byte_bits_msb: assert property ($fell(pins.scl_oe) && (pulses < 5'h08 ||
    (!rd && akd && pulses > 5'h08 && pulses < 5'h11)) |-> pins.sda_oe == !eb[bix]) else $error("wrong bit");

  c_read_nack: cover property ($fell(pins.scl_oe) && pulses == 5'h11 && rd);
  c_write_ack: cover property ($fell(pins.scl_oe) && pulses == 5'h11 && !rd);
  c_slverr: cover property (apb_rsp.pslverr);
endmodule

// File: bench/tb_i2csw_host.sv
// self-checking bench: apb stimulus, switch model on the wire
`timescale 1ns/10ps
`include "i2csw_params.svh"
module tb_i2csw_host;
  import i2csw_pkg::*;
  localparam logic [6:0] DEV = 7'h2a; // arbitrary switch address
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  i2csw_apb_req_type req = '0;
  i2csw_apb_rsp_type rsp;
  i2csw_pin_out_type pins;
  logic              m_oe;
  logic              scl_w;
  logic              sda_w;
  logic [7:0]        chan;
  logic [31:0]       r;
  logic              e;
  logic [7:0]        b;
  int                miscompares = 0;
  int                total_checks = 0;

  always #2.5 pclk = ~pclk;
  // open-drain wires with pull-ups
  assign scl_w = pins.scl_oe ? pins.scl_o : 1'b1;
  assign sda_w = (pins.sda_oe ? pins.sda_o : 1'b1) && !m_oe;

  i2csw_host #(.QTR_CYC(16'h0008), .RST_CYC(16'h0004)) dut_u (
    .pclk    (pclk),
    .presetn (presetn),
    .apb_req (req),
    .apb_rsp (rsp),
    .scl_i   (scl_w),
    .sda_i   (sda_w),
    .pins    (pins)
  );
  i2csw_switch_model #(.DEV_ADDR(DEV)) sw_u (
    .scl     (scl_w),
    .sda     (sda_w),
    .reset_n (pins.switch_reset_n),
    .sda_oe  (m_oe),
    .chan    (chan)
  );

  // one apb cycle; a spare edge keeps psel from two writes in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do
      @(posedge pclk);
    while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask

  // status polled until not busy
  task automatic poll();
    int n = 0;
    do
    begin
      apb(1'b0, `I2CSW_STAT_OFF, 32'h0);
      n++;
    end
    while (r[0] !== 1'b0 && n < 2000);
    if (n >= 2000) chk("poll_timeout", 32'h0, 32'(r[0]));
  endtask

  task automatic xfer(input logic rdn, input logic [6:0] a, input logic [7:0] d);
    apb(1'b1, `I2CSW_ADDR_OFF, {25'h0, a});
    apb(1'b1, `I2CSW_WDATA_OFF, {24'h0, d});
    apb(1'b1, `I2CSW_CTRL_OFF, {30'h0, rdn, 1'b1});
    poll();
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence: corners first, then random bytes
  initial
  begin
    b = 8'($urandom(32'h4a4b));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("chan_reset", 32'h0, 32'(chan));
    apb(1'b0, `I2CSW_CTRL_OFF, 32'h0);
    chk("ctrl_rst_pulse", 32'h4, r);
    apb(1'b0, `I2CSW_ADDR_OFF, 32'h0);
    chk("addr_reset", 32'h0, r);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped_err", 32'h1, 32'(e));
    poll();
    for (int i = 0; i < 10; i++)
    begin
      b = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      xfer(1'b0, DEV, b);
      chk("wr_status", 32'h2, r & 32'h7);
      chk("chan", 32'(b), 32'(chan));
      xfer(1'b1, DEV, ~b);
      chk("rd_byte", 32'(b), 32'(r[15:8]));
      apb(1'b0, `I2CSW_CTRL_OFF, 32'h0);
      chk("ctrl_dir", 32'h2, r);
    end
    // other address: refused, selection kept
    xfer(1'b0, DEV ^ 7'h01, ~b);
    chk("nack_status", 32'h6, r & 32'h7);
    chk("chan_kept", 32'(b), 32'(chan));
    // reset wins over go and deselects all
    apb(1'b1, `I2CSW_CTRL_OFF, 32'h5);
    poll();
    chk("chan_swrst", 32'h0, 32'(chan));
    // async reset in mid-transfer
    xfer(1'b0, DEV, 8'h5a);
    apb(1'b1, `I2CSW_CTRL_OFF, 32'h1);
    repeat (150) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("chan_async", 32'h0, 32'(chan));
    chk("lines_free", 32'h0, 32'({pins.scl_oe, pins.sda_oe}));
    presetn <= 1'b1;
    @(posedge pclk);
    poll();
    xfer(1'b1, DEV, 8'hff);
    chk("rd_after_rst", 32'h0, 32'(r[15:8]));
    give_verdict();
  end

  // watchdog against a hang
  initial
  begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule

bind i2csw_host i2csw_host_checker #(.QTR_CYC(QTR_CYC), .RST_CYC(RST_CYC)) chk_u (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .scl_i(scl_i), .sda_i(sda_i), .pins(pins));
